// ==== design/reclose_pkg.sv ====
package reclose_pkg;
	// time base
	localparam int unsigned CLK_PERIOD_NS = 20;
	localparam int unsigned TICK_PERIOD_NS = 10_000_000;
	localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int unsigned TICKS_PER_MINUTE = 6000;
	// timer width, enough for 1410 minutes of ticks
	localparam int unsigned TIMER_W = 24;
	// setting ranges and defaults
	localparam logic [6:0] BC_THRESHOLD_MAX = 7'h64;
	localparam logic [6:0] TRIP_RATE_MIN = 7'h02;
	localparam logic [6:0] TRIP_RATE_MAX = 7'h64;
	localparam logic [6:0] TRIP_RATE_DEFAULT = 7'h0A;
	localparam logic [10:0] WINDOW_MIN_MINUTES = 11'h001;
	localparam logic [10:0] WINDOW_MAX_MINUTES = 11'h582;
	localparam logic [10:0] WINDOW_DEFAULT_MINUTES = 11'h00A;
	localparam logic [15:0] INHIBIT_MAX_TICKS = 16'hEA60;
	localparam logic [15:0] INHIBIT_DEFAULT_TICKS = 16'h0064;
	// input blocking options
	localparam logic [1:0] BLOCK_NONE = 2'h0;
	localparam logic [1:0] BLOCK_LOCKOUT = 2'h1;
	localparam logic [1:0] BLOCK_TEMPORARY = 2'h2;
	// dead time start selection
	localparam logic DEAD_ON_PROTECTION_RESET = 1'b0;
	localparam logic DEAD_ON_BREAKER_TRIP = 1'b1;
	// signalling reset selection
	localparam logic SIGNAL_RESET_ON_RECLOSE = 1'b1;
endpackage

// ==== design/timer_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface timer_if #(parameter int unsigned W = 24);
	logic         start;
	logic         abort;
	logic [W-1:0] preset;
	logic         running;
	logic         done;
	modport owner (output start, output abort, output preset, input running, input done);
	modport timer (input start, input abort, input preset, output running, output done);
endinterface
`default_nettype wire

// ==== design/tick_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module tick_timer #(
	parameter int unsigned W = 24
) (
	// clock and resets
	input  wire logic clk_sys,
	input  wire logic arst_n,
	input  wire logic soft_reset,
	// time base
	input  wire logic tick,
	// control
	timer_if.timer    t
);
	logic [W-1:0] count_q;
	logic         running_q;
	logic         done_q;

	// counts ticks down from the preset, one done pulse at zero
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			count_q <= '0;
			running_q <= 1'b0;
			done_q <= 1'b0;
		end else if (soft_reset || t.abort) begin
			count_q <= '0;
			running_q <= 1'b0;
			done_q <= 1'b0;
		end else if (t.start) begin
			count_q <= t.preset;
			running_q <= (t.preset != '0);
			done_q <= (t.preset == '0);
		end else if (running_q && tick) begin
			count_q <= count_q - 1'b1;
			running_q <= (count_q != {{(W-1){1'b0}}, 1'b1});
			done_q <= (count_q == {{(W-1){1'b0}}, 1'b1});
		end else begin
			done_q <= 1'b0;
		end
	end

	assign t.running = running_q;
	assign t.done = done_q;
endmodule
`default_nettype wire

// ==== design/reclose_supervision_logic.sv ====
// Summary of operation
// - broken-conductor protection is disabled while the largest phase current is below the threshold (0 to 1.00 In, 0.01 In steps).
// - with the interlock enabled, inverse-time trips of earth and phase elements are blocked while any definite-time stage is started.
// - with breaker-fault monitoring on, an external breaker-fault input still active after its delay marks the breaker faulty and locks out reclosing.
// - with input blocking option 1, an active block input plus a trip belonging to the reclose matrix locks out reclosing.
// - every manual close command, with any input blocking option, blocks reclosing for the manual-close inhibit time.
// - with input blocking option 2, a breaker closure seen on the auxiliary contacts also starts that temporary block, but only while reclose is not in progress.
// - the dead time starts on breaker trip or on protection reset, as selected.
// - without breaker-state inputs the dead time always starts on protection reset.
// - with trip-rate supervision on, the first trip opens a window and reaching the maximum count of current trips in it gives a final trip.
// - the trip-rate maximum is held within 2 to 100, default 10.
// - the supervision window is 1 to 1410 minutes, default 10 minutes.
// - the manual-close inhibit time is 0 to 600 s in 10 ms steps, default 1 s, and blocks reclose initiation after a manual close.
// - lockout is cleared by a manual close once the inhibit time then elapses.
// - with signalling reset set, a reclose close command resets the LEDs and stored trip data; otherwise signalling is left alone.
`timescale 1ns/1ps
`default_nettype none
module reclose_supervision_logic #(
	parameter int unsigned TICK_CYCLES = reclose_pkg::TICK_CYCLES
) (
	// clock and resets
	input  wire logic        clk_sys,
	input  wire logic        arst_n,
	input  wire logic        soft_reset,
	// broken conductor
	input  wire logic [15:0] phase_a_current,
	input  wire logic [15:0] phase_b_current,
	input  wire logic [15:0] phase_c_current,
	input  wire logic [6:0]  bc_min_current,
	output logic             bc_enable_q,
	// overcurrent interlock
	input  wire logic        idmt_interlock_enable,
	input  wire logic        dmt_stage_started,
	input  wire logic [1:0]  idmt_trip_request,
	output logic [1:0]       idmt_trip_q,
	// reclose settings
	input  wire logic        breaker_fault_monitor_enable,
	input  wire logic [15:0] breaker_fault_external_delay,
	input  wire logic [1:0]  input_block_mode,
	input  wire logic        dead_time_select,
	input  wire logic        breaker_state_available,
	input  wire logic        trip_rate_enable,
	input  wire logic [6:0]  trip_rate_max,
	input  wire logic [10:0] trip_rate_window_minutes,
	input  wire logic [15:0] manual_close_inhibit_time,
	input  wire logic        signal_reset_mode,
	// plant and protection signals
	input  wire logic        breaker_fault_external_input,
	input  wire logic        reclose_block_input,
	input  wire logic        protection_trip,
	input  wire logic        trip_in_matrix,
	input  wire logic        trip_current_based,
	input  wire logic        manual_close_cmd,
	input  wire logic        reclose_close_cmd,
	input  wire logic        reclose_in_progress,
	input  wire logic        breaker_closed_aux_contact,
	input  wire logic        breaker_open_aux_contact,
	// reclose status
	output logic             breaker_faulty_q,
	output logic             lockout_q,
	output logic             reclose_blocked_q,
	output logic             dead_time_start_q,
	output logic             final_trip_q,
	output logic             signalling_reset_q
);
	localparam int unsigned W = reclose_pkg::TIMER_W;

	function automatic logic [6:0] clamp7(input logic [6:0] v, input logic [6:0] lo,
		input logic [6:0] hi);
		clamp7 = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	function automatic logic [15:0] max16(input logic [15:0] a, input logic [15:0] b);
		max16 = (a > b) ? a : b;
	endfunction

	// time base
	logic [$clog2(TICK_CYCLES+1)-1:0] div_q;
	logic                             tick_q;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			div_q <= '0;
			tick_q <= 1'b0;
		end else if (soft_reset) begin
			div_q <= '0;
			tick_q <= 1'b0;
		end else begin
			tick_q <= (div_q == $bits(div_q)'(TICK_CYCLES - 1));
			div_q <= (div_q == $bits(div_q)'(TICK_CYCLES - 1)) ? '0 : div_q + 1'b1;
		end
	end

	// broken conductor and interlock
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			bc_enable_q <= 1'b0;
			idmt_trip_q <= 2'h0;
		end else begin
			bc_enable_q <= max16(max16(phase_a_current, phase_b_current), phase_c_current)
				>= {9'h000, clamp7(bc_min_current, 7'h00, reclose_pkg::BC_THRESHOLD_MAX)};
			idmt_trip_q <= (idmt_interlock_enable && dmt_stage_started) ? 2'h0
				: idmt_trip_request;
		end
	end

	// edge history
	logic trip_prev_q;
	logic closed_prev_q;
	logic open_prev_q;
	logic edge_valid_q;
	// contact history only counts once it holds a real sample
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			trip_prev_q <= 1'b0;
			closed_prev_q <= 1'b0;
			open_prev_q <= 1'b0;
			edge_valid_q <= 1'b0;
		end else begin
			trip_prev_q <= protection_trip;
			closed_prev_q <= breaker_closed_aux_contact;
			open_prev_q <= breaker_open_aux_contact;
			edge_valid_q <= 1'b1;
		end
	end

	logic trip_rise;
	logic trip_fall;
	logic aux_closure;
	logic aux_opening;
	assign trip_rise = protection_trip && !trip_prev_q;
	assign trip_fall = !protection_trip && trip_prev_q;
	assign aux_closure = edge_valid_q && ((breaker_closed_aux_contact && !closed_prev_q)
		|| (!breaker_open_aux_contact && open_prev_q));
	assign aux_opening = edge_valid_q && ((!breaker_closed_aux_contact && closed_prev_q)
		|| (breaker_open_aux_contact && !open_prev_q));

	// timers
	timer_if #(.W(W)) bf_t ();
	timer_if #(.W(W)) inh_t ();
	timer_if #(.W(W)) win_t ();

	tick_timer #(.W(W)) u_bf_timer (.clk_sys(clk_sys), .arst_n(arst_n),
		.soft_reset(soft_reset), .tick(tick_q), .t(bf_t.timer));
	tick_timer #(.W(W)) u_inh_timer (.clk_sys(clk_sys), .arst_n(arst_n),
		.soft_reset(soft_reset), .tick(tick_q), .t(inh_t.timer));
	tick_timer #(.W(W)) u_win_timer (.clk_sys(clk_sys), .arst_n(arst_n),
		.soft_reset(soft_reset), .tick(tick_q), .t(win_t.timer));

	// breaker fault delay runs while the external input is held
	logic bf_in_prev_q;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			bf_in_prev_q <= 1'b0;
		end else begin
			bf_in_prev_q <= breaker_fault_monitor_enable && breaker_fault_external_input;
		end
	end
	assign bf_t.start = breaker_fault_monitor_enable && breaker_fault_external_input
		&& !bf_in_prev_q;
	assign bf_t.abort = !breaker_fault_external_input || !breaker_fault_monitor_enable;
	assign bf_t.preset = {{(W-16){1'b0}}, breaker_fault_external_delay};

	// manual close inhibit
	logic inh_start;
	assign inh_start = manual_close_cmd
		|| (input_block_mode == reclose_pkg::BLOCK_TEMPORARY
		&& aux_closure && !reclose_in_progress);
	assign inh_t.start = inh_start;
	assign inh_t.abort = 1'b0;
	assign inh_t.preset = {{(W-16){1'b0}}, (manual_close_inhibit_time > reclose_pkg::INHIBIT_MAX_TICKS)
		? reclose_pkg::INHIBIT_MAX_TICKS : manual_close_inhibit_time};

	// trip rate window
	logic [10:0] win_minutes;
	logic [6:0]  rate_max;
	logic        window_open_q;
	logic [6:0]  trip_count_q;
	logic        counted_trip;
	assign win_minutes = (trip_rate_window_minutes < reclose_pkg::WINDOW_MIN_MINUTES)
		? reclose_pkg::WINDOW_MIN_MINUTES
		: ((trip_rate_window_minutes > reclose_pkg::WINDOW_MAX_MINUTES)
		? reclose_pkg::WINDOW_MAX_MINUTES : trip_rate_window_minutes);
	assign rate_max = clamp7(trip_rate_max, reclose_pkg::TRIP_RATE_MIN,
		reclose_pkg::TRIP_RATE_MAX);
	assign counted_trip = trip_rate_enable && trip_rise && trip_current_based;
	assign win_t.start = trip_rate_enable && trip_rise && !window_open_q;
	assign win_t.abort = !trip_rate_enable;
	assign win_t.preset = W'({13'h0000, win_minutes} * 24'(reclose_pkg::TICKS_PER_MINUTE));

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			window_open_q <= 1'b0;
			trip_count_q <= 7'h00;
			final_trip_q <= 1'b0;
		end else if (soft_reset || !trip_rate_enable) begin
			window_open_q <= 1'b0;
			trip_count_q <= 7'h00;
			final_trip_q <= 1'b0;
		end else begin
			final_trip_q <= 1'b0;
			if (win_t.start) begin
				window_open_q <= 1'b1;
			end else if (win_t.done) begin
				window_open_q <= 1'b0;
			end
			if (counted_trip && (trip_count_q + 1'b1 >= rate_max)) begin
				final_trip_q <= 1'b1;
				trip_count_q <= 7'h00;
			end else if (counted_trip) begin
				trip_count_q <= trip_count_q + 1'b1;
			end else if (win_t.done) begin
				trip_count_q <= 7'h00;
			end
		end
	end

	// lockout, faulty breaker and temporary block
	logic close_pending_q;
	logic lock_set;
	assign lock_set = (breaker_fault_monitor_enable && bf_t.done
		&& breaker_fault_external_input)
		|| (input_block_mode == reclose_pkg::BLOCK_LOCKOUT && reclose_block_input
		&& trip_rise && trip_in_matrix)
		|| (counted_trip && (trip_count_q + 1'b1 >= rate_max));

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			lockout_q <= 1'b0;
			breaker_faulty_q <= 1'b0;
			close_pending_q <= 1'b0;
			reclose_blocked_q <= 1'b0;
		end else if (soft_reset) begin
			lockout_q <= 1'b0;
			breaker_faulty_q <= 1'b0;
			close_pending_q <= 1'b0;
			reclose_blocked_q <= 1'b0;
		end else begin
			reclose_blocked_q <= inh_t.running || inh_start;
			if (manual_close_cmd) begin
				close_pending_q <= 1'b1;
			end else if (inh_t.done) begin
				close_pending_q <= 1'b0;
			end
			if (lock_set) begin
				lockout_q <= 1'b1;
			end else if (close_pending_q && inh_t.done && !manual_close_cmd) begin
				lockout_q <= 1'b0;
			end
			if (breaker_fault_monitor_enable && bf_t.done && breaker_fault_external_input) begin
				breaker_faulty_q <= 1'b1;
			end else if (!breaker_fault_external_input) begin
				breaker_faulty_q <= 1'b0;
			end
		end
	end

	// dead time start and signalling reset
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			dead_time_start_q <= 1'b0;
			signalling_reset_q <= 1'b0;
		end else begin
			if (dead_time_select == reclose_pkg::DEAD_ON_BREAKER_TRIP && breaker_state_available) begin
				dead_time_start_q <= aux_opening;
			end else begin
				dead_time_start_q <= trip_fall;
			end
			signalling_reset_q <= reclose_close_cmd
				&& (signal_reset_mode == reclose_pkg::SIGNAL_RESET_ON_RECLOSE);
		end
	end

	// checks
	property p_interlock;
		@(posedge clk_sys) disable iff (!arst_n)
		idmt_interlock_enable && dmt_stage_started |=> idmt_trip_q == 2'h0;
	endproperty
	a_interlock: assert property (p_interlock) else $error("idmt trip passed interlock");

	property p_bc_low;
		@(posedge clk_sys) disable iff (!arst_n)
		phase_a_current < {9'h000, bc_min_current}
		&& phase_b_current < {9'h000, bc_min_current}
		&& phase_c_current < {9'h000, bc_min_current}
		&& bc_min_current <= reclose_pkg::BC_THRESHOLD_MAX |=> !bc_enable_q;
	endproperty
	a_bc_low: assert property (p_bc_low) else $error("broken conductor not disabled");

	property p_bf_lock;
		@(posedge clk_sys) disable iff (!arst_n || soft_reset)
		breaker_fault_monitor_enable && bf_t.done && breaker_fault_external_input
		|=> lockout_q && breaker_faulty_q;
	endproperty
	a_bf_lock: assert property (p_bf_lock) else $error("breaker fault did not lock out");

	property p_block_lock;
		@(posedge clk_sys) disable iff (!arst_n || soft_reset)
		input_block_mode == reclose_pkg::BLOCK_LOCKOUT && reclose_block_input
		&& $rose(protection_trip) && trip_in_matrix |=> lockout_q;
	endproperty
	a_block_lock: assert property (p_block_lock) else $error("block input did not lock out");

	property p_temp_block;
		@(posedge clk_sys) disable iff (!arst_n || soft_reset)
		manual_close_cmd && manual_close_inhibit_time != 16'h0000 |=> reclose_blocked_q [*2];
	endproperty
	a_temp_block: assert property (p_temp_block) else $error("no block after close");

	property p_aux_block;
		@(posedge clk_sys) disable iff (!arst_n || soft_reset)
		input_block_mode == reclose_pkg::BLOCK_TEMPORARY && $rose(breaker_closed_aux_contact)
		&& !reclose_in_progress |=> reclose_blocked_q;
	endproperty
	a_aux_block: assert property (p_aux_block) else $error("no block on aux closure");

	property p_dead_reset;
		@(posedge clk_sys) disable iff (!arst_n)
		!breaker_state_available && $fell(protection_trip) |=> dead_time_start_q;
	endproperty
	a_dead_reset: assert property (p_dead_reset) else $error("dead time not started");

	property p_final;
		@(posedge clk_sys) disable iff (!arst_n || soft_reset)
		final_trip_q |-> lockout_q && $past(trip_current_based);
	endproperty
	a_final: assert property (p_final) else $error("final trip without lockout");

	property p_sig;
		@(posedge clk_sys) disable iff (!arst_n)
		reclose_close_cmd |=> signalling_reset_q == $past(signal_reset_mode);
	endproperty
	a_sig: assert property (p_sig) else $error("signalling reset mismatch");

	c_final: cover property (@(posedge clk_sys) disable iff (!arst_n) final_trip_q);
	c_unlock: cover property (@(posedge clk_sys) disable iff (!arst_n) $fell(lockout_q));
	c_faulty: cover property (@(posedge clk_sys) disable iff (!arst_n) $rose(breaker_faulty_q));
endmodule
`default_nettype wire

// ==== verification/breaker_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module breaker_model (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic arst_n,
	// commands from bench
	input  wire logic open_cmd,
	input  wire logic close_cmd,
	input  wire logic slow,
	// auxiliary contacts
	output logic      breaker_closed_aux_contact,
	output logic      breaker_open_aux_contact
);
	logic       closed_q;
	logic       target_q;
	logic [3:0] wait_q;

	// mechanism travel time, prompt or slow, both contacts move together
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			closed_q <= 1'b1;
			target_q <= 1'b1;
			wait_q <= 4'h0;
		end else if (open_cmd || close_cmd) begin
			target_q <= close_cmd;
			wait_q <= slow ? 4'h6 : 4'h1;
		end else if (wait_q != 4'h0) begin
			wait_q <= wait_q - 4'h1;
			if (wait_q == 4'h1) begin
				closed_q <= target_q;
			end
		end
	end

	assign breaker_closed_aux_contact = closed_q;
	assign breaker_open_aux_contact = !closed_q;
endmodule
`default_nettype wire

// ==== verification/reclose_supervision_logic_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module reclose_supervision_logic_tb;
	localparam int TC = 4;
	logic clk_sys = 1'b0, arst_n = 1'b0, soft_reset = 1'b0;
	logic [15:0] phase_a_current = 16'h0000, phase_b_current = 16'h0000;
	logic [15:0] phase_c_current = 16'h0000;
	logic [6:0] bc_min_current = 7'h00, trip_rate_max = 7'h01;
	logic idmt_interlock_enable = 1'b0, dmt_stage_started = 1'b0;
	logic [1:0] idmt_trip_request = 2'h0, input_block_mode = 2'h0;
	logic breaker_fault_monitor_enable = 1'b0, dead_time_select = 1'b0;
	logic [15:0] breaker_fault_external_delay = 16'h0003;
	logic [15:0] manual_close_inhibit_time = 16'h0002;
	logic breaker_state_available = 1'b0, trip_rate_enable = 1'b0;
	logic [10:0] trip_rate_window_minutes = 11'h001;
	logic signal_reset_mode = 1'b0, breaker_fault_external_input = 1'b0;
	logic reclose_block_input = 1'b0, protection_trip = 1'b0, trip_in_matrix = 1'b0;
	logic trip_current_based = 1'b0, manual_close_cmd = 1'b0, reclose_close_cmd = 1'b0;
	logic reclose_in_progress = 1'b0, brk_open = 1'b0, brk_close = 1'b0, brk_slow = 1'b0;
	logic breaker_closed_aux_contact, breaker_open_aux_contact, bc_enable_q;
	logic [1:0] idmt_trip_q;
	logic breaker_faulty_q, lockout_q, reclose_blocked_q;
	logic dead_time_start_q, final_trip_q, signalling_reset_q;
	logic [31:0] lfsr_q = 32'h0000ADFA;
	int fails = 0, num_checks = 0, dead_cnt = 0, final_cnt = 0, sig_cnt = 0, blk_cnt = 0;
	int m, t;

	reclose_supervision_logic #(.TICK_CYCLES(TC)) i_reclose_supervision_logic (
		.clk_sys, .arst_n, .soft_reset, .phase_a_current, .phase_b_current,
		.phase_c_current, .bc_min_current, .bc_enable_q, .idmt_interlock_enable,
		.dmt_stage_started, .idmt_trip_request, .idmt_trip_q,
		.breaker_fault_monitor_enable, .breaker_fault_external_delay, .input_block_mode,
		.dead_time_select, .breaker_state_available, .trip_rate_enable, .trip_rate_max,
		.trip_rate_window_minutes, .manual_close_inhibit_time, .signal_reset_mode,
		.breaker_fault_external_input, .reclose_block_input, .protection_trip,
		.trip_in_matrix, .trip_current_based, .manual_close_cmd, .reclose_close_cmd,
		.reclose_in_progress, .breaker_closed_aux_contact, .breaker_open_aux_contact,
		.breaker_faulty_q, .lockout_q, .reclose_blocked_q, .dead_time_start_q,
		.final_trip_q, .signalling_reset_q);

	breaker_model i_breaker_model (.clk_sys, .arst_n, .open_cmd(brk_open),
		.close_cmd(brk_close), .slow(brk_slow), .breaker_closed_aux_contact,
		.breaker_open_aux_contact);

	always #10 clk_sys = !clk_sys;

	// pulse and level counters seen at each edge
	always @(posedge clk_sys) begin
		dead_cnt += (dead_time_start_q === 1'b1);
		final_cnt += (final_trip_q === 1'b1);
		sig_cnt += (signalling_reset_q === 1'b1);
		blk_cnt += (reclose_blocked_q === 1'b1);
	end

	function automatic logic [31:0] lfsr_next();
		lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
		return lfsr_q;
	endfunction

	function automatic logic flag(input int k);
		return (k == 0) ? lockout_q : (k == 1) ? breaker_faulty_q : reclose_blocked_q;
	endfunction

	task automatic step(input int c);
		repeat (c) @(posedge clk_sys);
		#1;
	endtask

	task automatic final_report();
		if (fails == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s expected %0h seen %0h", name, exp, seen);
		end
	endtask

	// bounded wait for a status level
	task automatic wait_flag(input int k, input logic v, input int maxc);
		int c;
		c = 0;
		while (flag(k) !== v && c < maxc) begin
			step(1);
			c++;
		end
		check("wait_flag", {31'h0, flag(k)}, {31'h0, v});
		if (flag(k) !== v) final_report();
	endtask

	task automatic trip(input logic cur);
		protection_trip = 1'b1;
		trip_current_based = cur;
		step(2);
		protection_trip = 1'b0;
		step(2);
	endtask

	task automatic pulse_soft();
		soft_reset = 1'b1;
		step(1);
		soft_reset = 1'b0;
		step(1);
	endtask

	initial begin
		step(5);
		arst_n = 1'b1;
		step(1);
		for (int i = 0; i < 24; i++) begin
			phase_a_current = {9'h000, 7'(lfsr_next())};
			phase_b_current = {9'h000, 7'(lfsr_next())};
			phase_c_current = {9'h000, 7'(lfsr_next())};
			bc_min_current = 7'(lfsr_next());
			t = (bc_min_current > 7'h64) ? 100 : bc_min_current;
			m = phase_a_current;
			if (phase_b_current > m) m = phase_b_current;
			if (phase_c_current > m) m = phase_c_current;
			step(2);
			check("bc_enable_q", bc_enable_q, m >= t);
		end
		for (int i = 0; i < 16; i++) begin
			{idmt_interlock_enable, dmt_stage_started, idmt_trip_request} = i[3:0];
			step(2);
			check("idmt_trip_q", idmt_trip_q, (i[3] && i[2]) ? 0 : i[1:0]);
		end
		for (int i = 0; i < 4; i++) begin
			{breaker_state_available, dead_time_select} = i[1:0];
			dead_cnt = 0;
			trip(1'b0);
			check("dead_on_reset", dead_cnt, (i == 3) ? 0 : 1);
		end
		for (int i = 0; i < 2; i++) begin
			signal_reset_mode = i[0];
			sig_cnt = 0;
			reclose_close_cmd = 1'b1;
			step(1);
			reclose_close_cmd = 1'b0;
			step(3);
			check("signalling_reset_q", sig_cnt, i);
		end
		for (int i = 0; i < 3; i++) begin
			input_block_mode = (i == 1) ? 2'h0 : 2'h2;
			reclose_in_progress = (i == 0);
			brk_slow = i[0];
			dead_cnt = 0;
			brk_open = 1'b1;
			step(1);
			brk_open = 1'b0;
			step(20);
			check("dead_on_breaker", dead_cnt, 1);
			blk_cnt = 0;
			brk_close = 1'b1;
			step(1);
			brk_close = 1'b0;
			step(12);
			check("aux_block", blk_cnt > 0, i == 2);
		end
		reclose_in_progress = 1'b0;
		input_block_mode = 2'h0;
		step(20);
		breaker_fault_monitor_enable = 1'b1;
		breaker_fault_external_input = 1'b1;
		step(2 * TC - 1);
		check("faulty_early", breaker_faulty_q, 0);
		wait_flag(1, 1'b1, 2 * TC + 4);
		check("fault_lockout", lockout_q, 1);
		breaker_fault_external_input = 1'b0;
		step(3);
		check("faulty_clear", breaker_faulty_q, 0);
		check("lockout_sticky", lockout_q, 1);
		manual_close_cmd = 1'b1;
		step(1);
		manual_close_cmd = 1'b0;
		check("inhibit_block", reclose_blocked_q, 1);
		wait_flag(0, 1'b0, 4 * TC + 4);
		check("inhibit_end", reclose_blocked_q, 0);
		trip_in_matrix = 1'b1;
		reclose_block_input = 1'b1;
		trip(1'b0);
		check("no_block_mode0", lockout_q, 0);
		input_block_mode = 2'h1;
		trip(1'b0);
		check("block_lockout", lockout_q, 1);
		pulse_soft();
		check("soft_clear", lockout_q, 0);
		input_block_mode = 2'h0;
		trip_rate_enable = 1'b1;
		final_cnt = 0;
		trip(1'b1);
		trip(1'b0);
		check("rate_one", final_cnt, 0);
		trip(1'b1);
		check("rate_final", final_cnt, 1);
		check("rate_lockout", lockout_q, 1);
		pulse_soft();
		final_cnt = 0;
		trip(1'b1);
		step(reclose_pkg::TICKS_PER_MINUTE * TC + 2 * TC);
		trip(1'b1);
		check("window_end", final_cnt, 0);
		trip(1'b1);
		check("window_new", final_cnt, 1);
		final_report();
	end

	initial begin
		#1500000;
		fails++;
		final_report();
	end
endmodule
`default_nettype wire
